/* File: bus_ctl_pkg.sv */
// Package of constants for the external bus control and handshake block.
package bus_ctl_pkg;
   localparam int NUM_IRQ = 3;
   localparam int NUM_FLAG = 4;
   localparam int NUM_DMA = 2;
   localparam int TIMER_W = 32;
   // Timer expiry pulse length in cycles.
   localparam int EXPIRY_CYCLES = 4;
   localparam logic [2:0] EXPIRY_LAST = 3'h3;
   // DMA channel numbers served by the external requests.
   localparam int DMA_CH_A = 7;
   localparam int DMA_CH_B = 8;
   // Bus ownership states.
   typedef enum logic [1:0] {OWN_IDLE, OWN_FLOAT, OWN_GRANT} host_own_t;
endpackage

/* File: sync2.sv */
// Two-flop synchronizer with a parameter width.
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Data.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   // The first stage feeds only the second stage.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule

/* File: expiry_pulse.sv */
// Timer expiry pulse stretcher of a fixed length.
`timescale 1ns/1ps
module expiry_pulse (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Trigger and pulse.
   input wire logic fire,
   output logic pulse
);
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   logic nxt_pulse;

   // A new zero crossing during a pulse restarts the full length.
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_pulse = pulse;
      if (fire) begin
         nxt_cnt = 3'h0;
         nxt_pulse = 1'b1;
      end else if (pulse) begin
         if (cnt_ff == bus_ctl_pkg::EXPIRY_LAST) begin
            nxt_pulse = 1'b0;
         end else begin
            nxt_cnt = cnt_ff + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 3'h0;
         pulse <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         pulse <= nxt_pulse;
      end
   end
endmodule

/* File: external_bus_host_control.sv */
// External bus control: acknowledge, suspend, host grant, host wait, flags, timer, DMA.
`timescale 1ns/1ps
module external_bus_host_control #(
   parameter int TW = bus_ctl_pkg::TIMER_W
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Memory acknowledge pin (open bidirectional, three signals).
   input wire logic ack_in,
   output logic ack_out,
   output logic ack_oe_n,
   // Suspend bus input, synchronous, active low.
   input wire logic suspend_bus_hiz_n,
   // Core external access request and its completion.
   input wire logic ext_access_req,
   output logic ext_access_done,
   output logic core_stall,
   // Configuration: bus master flag from arbitration.
   input wire logic is_bus_master,
   // Slave-side access into internal memory, synchronous and host.
   input wire logic sync_slave_access,
   input wire logic host_access,
   input wire logic int_mem_ready,
   // Bus three-state enable for address, data, selects, strobes (low drives).
   output logic bus_oe_n,
   // Host bus request and chip select, asynchronous active low.
   input wire logic host_bus_request_n,
   input wire logic chip_select_n,
   // Multiprocessor bus requests, active low, synchronous.
   input wire logic [5:0] multiproc_bus_requests_n,
   output logic mp_request_blocked,
   // Host bus grant pin as three signals.
   input wire logic host_bus_grant_in,
   output logic host_bus_grant_out,
   output logic host_bus_grant_oe_n,
   output logic host_grant_seen,
   // Host wait-acknowledge pin and its drive mode bit.
   input wire logic host_ack_drive_mode,
   output logic host_wait_ack_out,
   output logic host_wait_ack_oe_n,
   // Interrupt request lines and their modes (1 = edge).
   input wire logic [2:0] interrupt_request_lines_n,
   input wire logic [2:0] irq_edge_mode,
   input wire logic [2:0] irq_clear,
   output logic [2:0] irq_pending,
   // Testable flag pins.
   input wire logic [3:0] testable_io_pins_in,
   input wire logic [3:0] flag_is_output,
   input wire logic [3:0] flag_out_value,
   output logic [3:0] testable_io_pins_out,
   output logic [3:0] testable_io_pins_oe_n,
   output logic [3:0] flag_condition,
   // Timer.
   input wire logic timer_enable,
   input wire logic timer_load,
   input wire logic [TW-1:0] timer_load_value,
   output logic [TW-1:0] timer_count_value,
   output logic timer_expired_pulse,
   // External DMA requests and grants, active low.
   input wire logic [1:0] ext_dma_request_n,
   input wire logic [1:0] dma_xfer_done,
   output logic [1:0] dma_ch_start,
   output logic [1:0] ext_dma_grant_n
);

   // ---------------------------------------------------------------
   // Input synchronizers
   // ---------------------------------------------------------------
   logic hreq_s_n;
   logic cs_s_n;
   logic [2:0] irq_s_n;
   logic [1:0] dreq_s_n;
   logic [3:0] flag_s;
   logic ack_s;

   sync2 #(.W(11), .RST_VAL(11'h7ff)) u_sync_async (
      .mclk(mclk),
      .rst_n(rst_n),
      .d({host_bus_request_n, chip_select_n, interrupt_request_lines_n, ext_dma_request_n,
          testable_io_pins_in}),
      .q({hreq_s_n, cs_s_n, irq_s_n, dreq_s_n, flag_s})
   );

   // Acknowledge pin is treated as a pin input, so it is synchronized too.
   sync2 #(.W(1), .RST_VAL(1'b1)) u_sync_ack (
      .mclk(mclk),
      .rst_n(rst_n),
      .d(ack_in),
      .q(ack_s)
   );

   // ---------------------------------------------------------------
   // Suspend, acknowledge and host ownership
   // ---------------------------------------------------------------
   bus_ctl_pkg::host_own_t own_ff, nxt_own;
   logic susp_ff, nxt_susp;
   logic ack_keep_ff, nxt_ack_keep;
   logic done_ff, nxt_done;
   logic stall_ff, nxt_stall;
   logic bus_oe_n_ff, nxt_bus_oe_n;
   logic ack_out_ff, nxt_ack_out;
   logic ack_oe_n_ff, nxt_ack_oe_n;
   logic gnt_out_ff, nxt_gnt_out;
   logic gnt_oe_n_ff, nxt_gnt_oe_n;
   logic gnt_seen_ff, nxt_gnt_seen;
   logic blk_ff, nxt_blk;
   logic wack_out_ff, nxt_wack_out;
   logic wack_oe_n_ff, nxt_wack_oe_n;
   logic ack_eff;
   logic host_req;

   assign host_req = !hreq_s_n;
   // Acknowledge level used is the synchronized pin, registered once more every cycle.
   assign ack_eff = ack_keep_ff;

   always_comb begin
      nxt_own = own_ff;
      // Suspend sampled low floats the bus the following cycle.
      nxt_susp = !suspend_bus_hiz_n;
      nxt_ack_keep = ack_s;
      nxt_done = 1'b0;
      nxt_stall = 1'b0;
      nxt_blk = 1'b0;
      // Host request wins over processor bus requests.
      if (host_req && (multiproc_bus_requests_n != 6'h3f)) begin
         nxt_blk = 1'b1;
      end
      // Float first, then grant; hold until release.
      case (own_ff)
         bus_ctl_pkg::OWN_IDLE: begin
            if (host_req && is_bus_master) begin
               nxt_own = bus_ctl_pkg::OWN_FLOAT;
            end
         end
         bus_ctl_pkg::OWN_FLOAT: begin
            nxt_own = host_req ? bus_ctl_pkg::OWN_GRANT : bus_ctl_pkg::OWN_IDLE;
         end
         bus_ctl_pkg::OWN_GRANT: begin
            if (!host_req) begin
               nxt_own = bus_ctl_pkg::OWN_IDLE;
            end
         end
         default: nxt_own = bus_ctl_pkg::OWN_IDLE;
      endcase
      // Access completes only with acknowledge high and no suspend.
      if (ext_access_req && is_bus_master && own_ff == bus_ctl_pkg::OWN_IDLE) begin
         if (susp_ff || !suspend_bus_hiz_n || !ack_eff) begin
            nxt_stall = 1'b1;
         end else begin
            nxt_done = 1'b1;
         end
      end else if (ext_access_req) begin
         nxt_stall = 1'b1;
      end
      // Float when suspended, not master, or handed to the host.
      nxt_bus_oe_n = nxt_susp || !is_bus_master || (nxt_own != bus_ctl_pkg::OWN_IDLE);
      // Slave pulls acknowledge low while not ready.
      nxt_ack_out = 1'b0;
      nxt_ack_oe_n = 1'b1;
      if (sync_slave_access && !is_bus_master && !int_mem_ready) begin
         nxt_ack_oe_n = 1'b0;
      end
      // Only the master drives grant; others monitor it.
      nxt_gnt_oe_n = !is_bus_master;
      nxt_gnt_out = (own_ff == bus_ctl_pkg::OWN_FLOAT && host_req) || (own_ff == bus_ctl_pkg::OWN_GRANT && host_req)
         ? 1'b0 : 1'b1;
      nxt_gnt_seen = !host_bus_grant_in;
      nxt_wack_out = 1'b1;
      nxt_wack_oe_n = 1'b1;
      if (!cs_s_n && host_req) begin
         if (host_access && !int_mem_ready) begin
            nxt_wack_out = 1'b0;
            nxt_wack_oe_n = 1'b0;
         end else if (host_ack_drive_mode) begin
            nxt_wack_out = 1'b1;
            nxt_wack_oe_n = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         own_ff <= bus_ctl_pkg::OWN_IDLE;
         susp_ff <= 1'b0;
         ack_keep_ff <= 1'b1;
         done_ff <= 1'b0;
         stall_ff <= 1'b0;
         bus_oe_n_ff <= 1'b1;
         ack_out_ff <= 1'b0;
         ack_oe_n_ff <= 1'b1;
         gnt_out_ff <= 1'b1;
         gnt_oe_n_ff <= 1'b1;
         gnt_seen_ff <= 1'b0;
         blk_ff <= 1'b0;
         wack_out_ff <= 1'b1;
         wack_oe_n_ff <= 1'b1;
      end else begin
         own_ff <= nxt_own;
         susp_ff <= nxt_susp;
         ack_keep_ff <= nxt_ack_keep;
         done_ff <= nxt_done;
         stall_ff <= nxt_stall;
         bus_oe_n_ff <= nxt_bus_oe_n;
         ack_out_ff <= nxt_ack_out;
         ack_oe_n_ff <= nxt_ack_oe_n;
         gnt_out_ff <= nxt_gnt_out;
         gnt_oe_n_ff <= nxt_gnt_oe_n;
         gnt_seen_ff <= nxt_gnt_seen;
         blk_ff <= nxt_blk;
         wack_out_ff <= nxt_wack_out;
         wack_oe_n_ff <= nxt_wack_oe_n;
      end
   end

   assign ext_access_done = done_ff;
   assign core_stall = stall_ff;
   assign bus_oe_n = bus_oe_n_ff;
   assign ack_out = ack_out_ff;
   assign ack_oe_n = ack_oe_n_ff;
   assign host_bus_grant_out = gnt_out_ff;
   assign host_bus_grant_oe_n = gnt_oe_n_ff;
   assign host_grant_seen = gnt_seen_ff;
   assign mp_request_blocked = blk_ff;
   assign host_wait_ack_out = wack_out_ff;
   assign host_wait_ack_oe_n = wack_oe_n_ff;

   // ---------------------------------------------------------------
   // Interrupts and flags
   // ---------------------------------------------------------------
   logic [2:0] irq_prev_ff, nxt_irq_prev;
   logic [2:0] irq_pend_ff, nxt_irq_pend;
   logic [3:0] flag_out_ff, nxt_flag_out;
   logic [3:0] flag_oe_n_ff, nxt_flag_oe_n;
   logic [3:0] flag_cond_ff, nxt_flag_cond;

   always_comb begin
      nxt_irq_prev = irq_s_n;
      // Edge mode latches falling edges; a new edge beats the clear.
      for (int i = 0; i < bus_ctl_pkg::NUM_IRQ; i++) begin
         if (irq_edge_mode[i]) begin
            nxt_irq_pend[i] = (irq_prev_ff[i] && !irq_s_n[i]) || (irq_pend_ff[i] && !irq_clear[i]);
         end else begin
            nxt_irq_pend[i] = !irq_s_n[i];
         end
      end
      // Direction per pin; the condition is the input level on input pins and the driven value on output pins.
      nxt_flag_oe_n = ~flag_is_output;
      nxt_flag_out = flag_out_value;
      nxt_flag_cond = (flag_is_output & flag_out_value) | (~flag_is_output & flag_s);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_prev_ff <= 3'h7;
         irq_pend_ff <= 3'h0;
         flag_out_ff <= 4'h0;
         flag_oe_n_ff <= 4'hf;
         flag_cond_ff <= 4'h0;
      end else begin
         irq_prev_ff <= nxt_irq_prev;
         irq_pend_ff <= nxt_irq_pend;
         flag_out_ff <= nxt_flag_out;
         flag_oe_n_ff <= nxt_flag_oe_n;
         flag_cond_ff <= nxt_flag_cond;
      end
   end

   assign irq_pending = irq_pend_ff;
   assign testable_io_pins_out = flag_out_ff;
   assign testable_io_pins_oe_n = flag_oe_n_ff;
   assign flag_condition = flag_cond_ff;

   // ---------------------------------------------------------------
   // Timer and DMA handshake
   // ---------------------------------------------------------------
   logic [TW-1:0] tcnt_ff, nxt_tcnt;
   logic fire_ff, nxt_fire;
   logic [1:0] dstart_ff, nxt_dstart;
   logic [1:0] dgnt_n_ff, nxt_dgnt_n;
   logic [1:0] dbusy_ff, nxt_dbusy;

   always_comb begin
      nxt_tcnt = tcnt_ff;
      nxt_fire = 1'b0;
      if (timer_load) begin
         nxt_tcnt = timer_load_value;
      end else if (timer_enable && tcnt_ff != '0) begin
         nxt_tcnt = tcnt_ff - 1'b1;
         // Decrement reaching zero fires the pulse.
         nxt_fire = (tcnt_ff == {{(TW-1){1'b0}}, 1'b1});
      end
      // Request starts channel, matching grant answers at completion.
      for (int i = 0; i < bus_ctl_pkg::NUM_DMA; i++) begin
         nxt_dstart[i] = !dreq_s_n[i] && !dbusy_ff[i];
         nxt_dbusy[i] = (dbusy_ff[i] && !dma_xfer_done[i]) || nxt_dstart[i];
         nxt_dgnt_n[i] = !(dbusy_ff[i] && dma_xfer_done[i]);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tcnt_ff <= '0;
         fire_ff <= 1'b0;
         dstart_ff <= 2'h0;
         dgnt_n_ff <= 2'h3;
         dbusy_ff <= 2'h0;
      end else begin
         tcnt_ff <= nxt_tcnt;
         fire_ff <= nxt_fire;
         dstart_ff <= nxt_dstart;
         dgnt_n_ff <= nxt_dgnt_n;
         dbusy_ff <= nxt_dbusy;
      end
   end

   expiry_pulse u_expiry (
      .mclk(mclk),
      .rst_n(rst_n),
      .fire(fire_ff),
      .pulse(timer_expired_pulse)
   );

   assign timer_count_value = tcnt_ff;
   assign dma_ch_start = dstart_ff;
   assign ext_dma_grant_n = dgnt_n_ff;
endmodule

/* File: ebhc_sva.sv */
// Checker of the external bus control block's port behaviour.
`timescale 1ns/1ps
module ebhc_sva (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Watched ports.
   input wire logic suspend_bus_hiz_n,
   input wire logic ext_access_done,
   input wire logic bus_oe_n,
   input wire logic is_bus_master,
   input wire logic host_bus_request_n,
   input wire logic chip_select_n,
   input wire logic [5:0] multiproc_bus_requests_n,
   input wire logic mp_request_blocked,
   input wire logic host_bus_grant_out,
   input wire logic host_bus_grant_oe_n,
   input wire logic host_access,
   input wire logic int_mem_ready,
   input wire logic host_ack_drive_mode,
   input wire logic host_wait_ack_out,
   input wire logic host_wait_ack_oe_n,
   input wire logic timer_expired_pulse
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   susp_float_a: assert property (!suspend_bus_hiz_n ##1 !suspend_bus_hiz_n |-> ##1 bus_oe_n)
      else $error("bus driven under suspend");
   susp_stall_a: assert property (!suspend_bus_hiz_n [*2] |-> ##1 !ext_access_done)
      else $error("access completed under suspend");
   grant_float_a: assert property (!host_bus_grant_out && !host_bus_grant_oe_n |-> bus_oe_n)
      else $error("bus driven while host granted");
   host_prio_a: assert property ((!host_bus_request_n && !(&multiproc_bus_requests_n)) [*4]
      |-> mp_request_blocked)
      else $error("processor request not blocked");
   grant_hold_a: assert property ((is_bus_master && !host_bus_request_n) [*4] ##0 !host_bus_grant_out
      |=> !host_bus_grant_out)
      else $error("grant dropped during request");
   grant_release_a: assert property ($rose(host_bus_request_n) && !host_bus_grant_out
      |-> ##[1:4] host_bus_grant_out)
      else $error("grant not released");
   slave_grant_a: assert property (!is_bus_master [*3] |-> host_bus_grant_oe_n)
      else $error("slave drives grant");
   wait_low_a: assert property ((host_access && !int_mem_ready && !chip_select_n && !host_bus_request_n) [*4]
      |-> !host_wait_ack_oe_n && !host_wait_ack_out)
      else $error("no wait on unready host access");
   open_drain_a: assert property (!host_ack_drive_mode [*2] ##0 !host_wait_ack_oe_n |-> !host_wait_ack_out)
      else $error("open drain output driven high");
   wait_undriven_a: assert property ((chip_select_n || host_bus_request_n) [*4] |-> host_wait_ack_oe_n)
      else $error("wait ack driven without select");
   pulse_len_a: assert property ($rose(timer_expired_pulse)
      |-> timer_expired_pulse [*4] ##1 !timer_expired_pulse)
      else $error("expiry pulse length wrong");
   // Main scenarios reached.
   grant_c: cover property (!host_bus_grant_out && !host_bus_grant_oe_n);
   pulse_c: cover property ($rose(timer_expired_pulse));
   wait_c: cover property (!host_wait_ack_oe_n && host_wait_ack_out);
endmodule
bind external_bus_host_control ebhc_sva chk (.mclk(mclk), .rst_n(rst_n), .suspend_bus_hiz_n(suspend_bus_hiz_n),
   .ext_access_done(ext_access_done), .bus_oe_n(bus_oe_n), .is_bus_master(is_bus_master),
   .host_bus_request_n(host_bus_request_n), .chip_select_n(chip_select_n),
   .multiproc_bus_requests_n(multiproc_bus_requests_n), .mp_request_blocked(mp_request_blocked),
   .host_bus_grant_out(host_bus_grant_out), .host_bus_grant_oe_n(host_bus_grant_oe_n),
   .host_access(host_access), .int_mem_ready(int_mem_ready), .host_ack_drive_mode(host_ack_drive_mode),
   .host_wait_ack_out(host_wait_ack_out), .host_wait_ack_oe_n(host_wait_ack_oe_n),
   .timer_expired_pulse(timer_expired_pulse));

/* File: host_model.sv */
// Behavioural host that requests the bus and selects the device.
`timescale 1ns/1ps
module host_model (
   // Clock.
   input wire logic mclk,
   // Test controls.
   input wire logic want_bus,
   input wire logic want_sel,
   // Pins toward the device.
   output logic host_bus_request_n,
   output logic chip_select_n
);
   // The pins follow the test controls at once, so they move on the falling edge
   // where the bench changes them and no process order can shift them a cycle.
   // Request and select.
   assign host_bus_request_n = !want_bus;
   assign chip_select_n = !(want_bus && want_sel);
endmodule

/* File: tb_top.sv */
// Self-checking testbench of the external bus control block.
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0, rst_n = 1'b0, ack_drv = 1'b1, want_bus = 1'b0, want_sel = 1'b1;
   logic suspend_bus_hiz_n = 1'b1, ext_access_req = 1'b0, is_bus_master = 1'b1;
   logic sync_slave_access = 1'b0, host_access = 1'b0, int_mem_ready = 1'b1, host_ack_drive_mode = 1'b0;
   logic [5:0] multiproc_bus_requests_n = 6'h3f;
   logic [2:0] irq_n = 3'h7, irq_edge_mode = 3'h1, irq_clear = 3'h0, irq_pending;
   logic [3:0] flag_ext = 4'ha, flag_is_output = 4'h0, flag_out_value = 4'h0, pins_in, pins_out, pins_oe_n, flag_cond;
   logic timer_enable = 1'b0, timer_load = 1'b0, timer_expired_pulse;
   logic [31:0] timer_load_value = 32'h0000_0000, timer_count_value;
   logic [1:0] dma_req_n = 2'h3, dma_xfer_done = 2'h0, dma_ch_start, ext_dma_grant_n;
   logic ack_in, ack_out, ack_oe_n, ext_access_done, core_stall, bus_oe_n, host_bus_request_n, chip_select_n;
   logic mp_request_blocked, grant_in, grant_out, grant_oe_n, host_grant_seen, wait_out, wait_oe_n;
   int err_count = 0, num_checks = 0, cycles = 0, i, c;
   // ----------------------------------------
   // Pins, partner and device
   // ----------------------------------------
   // Shared lines: a party that floats lets the pull-up or the far driver win.
   assign ack_in = ack_oe_n ? ack_drv : (ack_out & ack_drv);
   assign grant_in = grant_oe_n ? 1'b1 : grant_out;
   assign pins_in = (pins_oe_n & flag_ext) | (~pins_oe_n & pins_out);
   host_model hm (.mclk(mclk), .want_bus(want_bus), .want_sel(want_sel), .host_bus_request_n(host_bus_request_n),
      .chip_select_n(chip_select_n));
   external_bus_host_control dut (.mclk(mclk), .rst_n(rst_n), .ack_in(ack_in), .ack_out(ack_out), .ack_oe_n(ack_oe_n),
      .suspend_bus_hiz_n(suspend_bus_hiz_n), .ext_access_req(ext_access_req), .ext_access_done(ext_access_done),
      .core_stall(core_stall), .is_bus_master(is_bus_master), .sync_slave_access(sync_slave_access),
      .host_access(host_access), .int_mem_ready(int_mem_ready), .bus_oe_n(bus_oe_n),
      .host_bus_request_n(host_bus_request_n), .chip_select_n(chip_select_n),
      .multiproc_bus_requests_n(multiproc_bus_requests_n), .mp_request_blocked(mp_request_blocked),
      .host_bus_grant_in(grant_in), .host_bus_grant_out(grant_out), .host_bus_grant_oe_n(grant_oe_n),
      .host_grant_seen(host_grant_seen), .host_ack_drive_mode(host_ack_drive_mode), .host_wait_ack_out(wait_out),
      .host_wait_ack_oe_n(wait_oe_n), .interrupt_request_lines_n(irq_n), .irq_edge_mode(irq_edge_mode),
      .irq_clear(irq_clear), .irq_pending(irq_pending), .testable_io_pins_in(pins_in), .flag_is_output(flag_is_output),
      .flag_out_value(flag_out_value), .testable_io_pins_out(pins_out), .testable_io_pins_oe_n(pins_oe_n),
      .flag_condition(flag_cond), .timer_enable(timer_enable), .timer_load(timer_load),
      .timer_load_value(timer_load_value), .timer_count_value(timer_count_value),
      .timer_expired_pulse(timer_expired_pulse), .ext_dma_request_n(dma_req_n), .dma_xfer_done(dma_xfer_done),
      .dma_ch_start(dma_ch_start), .ext_dma_grant_n(ext_dma_grant_n));
   // The 10 MHz clock.
   initial begin
      forever #50 mclk = ~mclk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // A hang ends the run well past the hundred or so cycles the tests need.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         complete_run();
      end
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      cyc(3);
      chk("bus_oe_n", bus_oe_n, 1'h1);
      chk("wait_oe_n", wait_oe_n, 1'h1);
      chk("grant_oe_n", grant_oe_n, 1'h1);
      chk("dma_grant", ext_dma_grant_n, 2'h3);
      cyc(1);
      rst_n = 1'b1;
      ack_drv = 1'b0;
      cyc(4);
      ext_access_req = 1'b1;
      cyc(6);
      chk("ack_stall", {core_stall, ext_access_done}, 2'h2);
      ack_drv = 1'b1;
      for (i = 0; i < 10 && ext_access_done !== 1'b1; i++) cyc(1);
      chk("ack_done", ext_access_done, 1'h1);
      ext_access_req = 1'b0;
      suspend_bus_hiz_n = 1'b0;
      cyc(3);
      ext_access_req = 1'b1;
      cyc(3);
      chk("susp", {bus_oe_n, core_stall, ext_access_done}, 3'h6);
      suspend_bus_hiz_n = 1'b1;
      for (i = 0; i < 10 && ext_access_done !== 1'b1; i++) cyc(1);
      chk("susp_done", ext_access_done, 1'h1);
      ext_access_req = 1'b0;
      // Host takes the bus while a processor also asks, and reads unready memory.
      multiproc_bus_requests_n = 6'h3e;
      host_access = 1'b1;
      int_mem_ready = 1'b0;
      want_bus = 1'b1;
      for (i = 0; i < 20 && grant_out !== 1'b0; i++) cyc(1);
      chk("grant", {grant_out, grant_oe_n, bus_oe_n, mp_request_blocked}, 4'h3);
      chk("wait_low", {wait_oe_n, wait_out}, 2'h0);
      cyc(6);
      chk("grant_held", {grant_out, host_grant_seen}, 2'h1);
      int_mem_ready = 1'b1;
      cyc(2);
      chk("wait_od", wait_oe_n, 1'h1);
      host_ack_drive_mode = 1'b1;
      cyc(2);
      chk("wait_active", {wait_oe_n, wait_out}, 2'h1);
      want_sel = 1'b0;
      cyc(5);
      chk("wait_nosel", wait_oe_n, 1'h1);
      want_bus = 1'b0;
      want_sel = 1'b1;
      for (i = 0; i < 10 && grant_out !== 1'b1; i++) cyc(1);
      chk("grant_rel", grant_out, 1'h1);
      // As a slave the device holds off a synchronous access and leaves grant alone.
      is_bus_master = 1'b0;
      sync_slave_access = 1'b1;
      int_mem_ready = 1'b0;
      want_bus = 1'b1;
      cyc(6);
      chk("slave", {ack_oe_n, ack_out, bus_oe_n, grant_oe_n}, 4'h3);
      want_bus = 1'b0;
      sync_slave_access = 1'b0;
      is_bus_master = 1'b1;
      // Edge line 0, level lines 1 and 2.
      irq_n = 3'h6;
      cyc(2);
      irq_n = 3'h7;
      cyc(4);
      chk("irq_edge", irq_pending, 3'h1);
      irq_clear = 3'h1;
      irq_n = 3'h3;
      cyc(1);
      irq_clear = 3'h0;
      cyc(4);
      chk("irq_level", irq_pending, 3'h4);
      irq_n = 3'h7;
      cyc(4);
      chk("irq_idle", irq_pending, 3'h0);
      flag_is_output = 4'h5;
      flag_out_value = 4'h1;
      cyc(4);
      chk("flag_oe", pins_oe_n, 4'ha);
      chk("flag_cond", {pins_out & 4'h5, flag_cond}, 8'h1b);
      timer_load_value = 32'h0000_0003;
      timer_load = 1'b1;
      cyc(1);
      chk("timer_count_value", timer_count_value, 32'h0000_0003);
      timer_load = 1'b0;
      timer_enable = 1'b1;
      for (i = 0; i < 20 && timer_expired_pulse !== 1'b1; i++) cyc(1);
      for (i = 0; i < 10 && timer_expired_pulse === 1'b1; i++) cyc(1);
      chk("pulse_len", i, 4);
      chk("timer_count_value_end", timer_count_value, 32'h0000_0000);
      timer_enable = 1'b0;
      // Each request starts only its own channel and ends in its own grant.
      for (c = 0; c < 2; c++) begin
         dma_req_n[c] = 1'b0;
         for (i = 0; i < 10 && dma_ch_start[c] !== 1'b1; i++) cyc(1);
         chk("dma_start", dma_ch_start, (c == 0) ? 2'h1 : 2'h2);
         dma_req_n[c] = 1'b1;
         cyc(2);
         dma_xfer_done[c] = 1'b1;
         cyc(1);
         dma_xfer_done[c] = 1'b0;
         for (i = 0; i < 10 && ext_dma_grant_n[c] !== 1'b0; i++) cyc(1);
         chk("dma_grant", ext_dma_grant_n, (c == 0) ? 2'h2 : 2'h1);
      end
      complete_run();
   end
endmodule
